// *** gsc_dev.sv ***
// Device end of the gyro SPI command/response link.
// Assumes the master keeps CPOL=CPHA=0 and a 0.1 us gap between frames.
// Assumes device data arrives on mclk and stays put for a few cycles.
//
// Functional notes
// R01 - Frame is 32 bits, full duplex
// R02 - Answer comes one frame later
// R03 - Mode 0: idle low, sample rising
// R04 - First answer is 0x00000001
// R05 - Master gives exactly 32 clocks
// R06 - Chip select active low frames transfer
// R07 - Sensor-data command bit layout
// R08 - Read/write command bit layout
// R09 - Sensor-data response bit layout
// R10 - Read/write response bit layout
// R11 - Error response bit layout
// R12 - Snapshot device data at select fall
// R13 - Load prepared response at select rise
// R14 - Master keeps select high 0.1 us
// R15 - Response data is previous snapshot
// R16 - Echo sequence tag unchanged
// R17 - Module select always reads 000
// R18 - Upper half odd parity bit
// R19 - Whole frame odd parity bit
// R20 - Command odd parity checked
// R21 - Response kind encodes data content
// R22 - Frame error: bad count or parity
// R23 - Bad command, register, or write
// R24 - Unassigned response bits are zero
module gsc_dev
  import gsc_pkg::*;
(
  // Link side, clocked by the master's serial clock
  gsc_if.dev spi,
  // Device side, on mclk
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] rate_word,
  input wire logic rate_valid,
  input wire logic selftest_mode,
  input wire logic [5:0] fault_flags,
  output logic [15:0] snap_rate,
  output logic frames_done
);
  // ----------------------------------------------------------------
  // Snapshot on mclk; chip select crosses in through two flops
  // ----------------------------------------------------------------
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic [15:0] snap_rate_ff;
  logic [1:0] snap_kind_ff;
  logic [5:0] snap_fault_ff;
  logic snap_du_ff;
  logic frames_done_ff;

  // Double sync of chip select, third flop for edge detect
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= spi.cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end

  // Latch device data when select falls; held stable for the whole frame [R12] [R15]
  // Select is seen two to three mclk late; a frame of 32 link clocks is far longer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snap_rate_ff <= 16'h0000;
      snap_kind_ff <= KIND_INVALID;
      snap_fault_ff <= 6'h00;
      snap_du_ff <= 1'b1;
    end else if (cs_s3_ff && !cs_s2_ff) begin
      snap_rate_ff <= rate_word;
      snap_kind_ff <= !rate_valid ? KIND_INVALID : (selftest_mode ? KIND_SELFTEST : KIND_VALID); // [R21]
      snap_fault_ff <= fault_flags;
      snap_du_ff <= 1'b0;
    end
  end

  // Toggle once per completed frame as a visible heartbeat
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frames_done_ff <= 1'b0;
    end else if (!cs_s3_ff && cs_s2_ff) begin
      frames_done_ff <= ~frames_done_ff;
    end
  end

  assign snap_rate = snap_rate_ff;
  assign frames_done = frames_done_ff;

  // ----------------------------------------------------------------
  // Link domain on sclk; snapshot is quasi-static while cs_n low,
  // so it is read directly there (settled a few mclk after select falls, long before it rises)
  // ----------------------------------------------------------------
  logic [31:0] rx_ff;
  logic [5:0] cnt_ff;
  logic [15:0] mem_ff [MEM_WORDS];
  logic [31:0] nxt_rx;
  logic [31:0] rsp;

  // Next shift value, MSB first
  assign nxt_rx = {rx_ff[30:0], spi.mosi};

  // Shift in on rising edge; count clocks in the frame [R01] [R03]
  // Count saturates at 63, so an over-long frame cannot wrap back to 32 [R22]
  always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      cnt_ff <= 6'h00;
    end else begin
      rx_ff <= nxt_rx;
      if (cnt_ff != 6'h3F) cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // Build the response for the command just received
  // Select rise captures whatever this shows then; it settles long before
  always_comb begin
    logic [2:0] kind;
    logic par_ok, len_ok, is_sd, is_rd, is_wr, idx_ok;
    logic [8:0] idx;
    kind = rx_ff[31:29];
    idx = rx_ff[REG_IDX_HI:REG_IDX_LO];
    par_ok = ^rx_ff;                                  // [R20]
    len_ok = (cnt_ff == 6'(FRAME_BITS));              // [R05] [R22]
    is_sd = rx_ff[CMD_SD_BIT];                        // [R07]
    is_rd = (kind == CMD_READ);                       // [R08]
    is_wr = (kind == CMD_WRITE);
    idx_ok = (idx < 9'(MEM_WORDS)) && (!is_wr || idx < WR_LIMIT);
    rsp = 32'h00000000;                               // [R24]
    if (!par_ok || !len_ok || (!is_sd && !(is_rd || is_wr)) || (!is_sd && !idx_ok) || (is_sd && snap_du_ff)) begin
      // Error answer [R11] [R22] [R23]
      rsp[31:29] = RSP_ERROR;
      rsp[27:24] = RSP_PATTERN;
      rsp[23:21] = MODULE_SELECT_VAL;                 // [R17]
      rsp[18] = !par_ok || !len_ok;
      rsp[17] = par_ok && len_ok && !is_sd && !(is_rd && idx_ok) && !(is_wr && idx_ok);
      rsp[16] = is_sd && snap_du_ff;
      // Only a sensor request carries a fault-test bit; in a write it is payload
      rsp[7:1] = {snap_fault_ff, is_sd && rx_ff[CMD_CHK_BIT]};
    end else if (is_sd) begin
      // Sensor data answer [R09] [R16]
      rsp[31:29] = {rx_ff[CMD_SQ2_BIT], rx_ff[31:30]};
      rsp[27:26] = snap_kind_ff;                      // [R21]
      rsp[25:10] = snap_rate_ff;                      // [R15]
      rsp[7:1] = {snap_fault_ff, rx_ff[CMD_CHK_BIT]};
    end else begin
      // Read or write answer [R10]
      rsp[31:29] = is_rd ? RSP_READ : RSP_WRITE;
      rsp[27:24] = RSP_PATTERN;
      rsp[23:21] = MODULE_SELECT_VAL;                 // [R17]
      rsp[20:5] = is_wr ? rx_ff[PAYLOAD_HI:PAYLOAD_LO] : mem_ff[idx[3:0]];
    end
    rsp[28] = odd_fill({16'h0000, rsp[31:16]});      // [R18]
    rsp[0] = odd_fill({rsp[31:1], 1'b0});             // [R19]
  end

  // ----------------------------------------------------------------
  // Small register memory, written when chip select rises
  // ----------------------------------------------------------------
  // A write takes effect only with a full count, odd parity, the write
  // code and a writable index. Content after reset is left undefined,
  // so a read before any write returns unknowns.
  function automatic logic write_lands(input logic [31:0] w, input logic [5:0] n);
    write_lands = (n == 6'(FRAME_BITS)) && (^w) && (w[31:29] == CMD_WRITE) &&
                  (w[REG_IDX_HI:REG_IDX_LO] < WR_LIMIT);
  endfunction

  // Index bits above 3 are zero for any writable word, so 4 bits address it
  always_ff @(posedge spi.cs_n) begin
    if (write_lands(rx_ff, cnt_ff)) begin
      mem_ff[rx_ff[20:17]] <= rx_ff[PAYLOAD_HI:PAYLOAD_LO];
    end
  end

  // ----------------------------------------------------------------
  // Transmit side: answer loaded on select rise, sent next frame
  // ----------------------------------------------------------------
  // The reset value is the fixed first answer, so no first-frame flag is
  // needed. Reset must come while select is high: a reset in mid-frame
  // leaves the bit pointer where the frame left it.
  logic [31:0] load_ff;
  always_ff @(posedge spi.cs_n or negedge nrst) begin
    if (!nrst) begin
      load_ff <= FIRST_RESPONSE;                      // [R04]
    end else begin
      load_ff <= rsp;                                 // [R02] [R13]
    end
  end

  // Bit pointer: counts down on falling sclk, parked at 31 while deselected
  logic [4:0] tx_bit_ff;
  always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      tx_bit_ff <= FRAME_LAST;
    end else begin
      tx_bit_ff <= tx_bit_ff - 5'h01;
    end
  end

  // MISO is a mux, not a flop: the first bit must stand as soon as select falls
  assign spi.miso = load_ff[tx_bit_ff];               // [R01] [R03]
  // Output enabled only inside a frame
  assign spi.miso_oe_n = spi.cs_n;                    // [R06]
endmodule

// *** gsc_pkg.sv ***
// Package for the gyro SPI command/response link: frame layout, codes, timing.
// Assumes both ends and the bench import it whole.
package gsc_pkg;
  // ----------------------------------------------------------------
  // Frame and field layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam logic [4:0] FRAME_LAST = 5'h1F;
  localparam int CMD_KIND_HI = 31;
  localparam int CMD_SD_BIT = 29;
  localparam int CMD_SQ2_BIT = 28;
  localparam int CMD_CHK_BIT = 1;
  localparam int REG_IDX_HI = 25;
  localparam int REG_IDX_LO = 17;
  localparam int PAYLOAD_HI = 16;
  localparam int PAYLOAD_LO = 1;
  localparam logic [2:0] CMD_READ = 3'h4;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] RSP_READ = 3'h2;
  localparam logic [2:0] RSP_WRITE = 3'h1;
  localparam logic [2:0] RSP_ERROR = 3'h0;
  localparam logic [3:0] RSP_PATTERN = 4'hE;
  localparam logic [2:0] MODULE_SELECT_VAL = 3'h0;
  localparam logic [31:0] FIRST_RESPONSE = 32'h00000001;
  localparam logic [31:0] CMD_RESET_VAL = 32'h00000000;
  // Response kinds
  localparam logic [1:0] KIND_INVALID = 2'h0;
  localparam logic [1:0] KIND_VALID = 2'h1;
  localparam logic [1:0] KIND_SELFTEST = 2'h2;
  localparam logic [1:0] KIND_RW = 2'h3;
  // Number of implemented memory words, writable ones are below WR_LIMIT
  localparam int MEM_WORDS = 16;
  localparam logic [8:0] WR_LIMIT = 9'h008;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_NS = 100.0;
  localparam real GAP_US = 0.1;
  localparam int GAP_CYC = (int'($ceil(GAP_US * 1000.0 / CLK_NS)) < 1) ? 1 : int'($ceil(GAP_US * 1000.0 / CLK_NS));
  // Host sclk half period minus one, in mclk; three mclk per half so MISO clears the host's two-flop sync
  localparam logic [3:0] HDIV = 4'h2;
  // Odd parity bit: value that makes the vector plus the bit odd
  function automatic logic odd_fill(input logic [31:0] v);
    odd_fill = ~(^v);
  endfunction
endpackage

// *** gsc_if.sv ***
// Interface carrying the four SPI wires between host and device.
// Assumes the bench instantiates it; on the second instance the bench drives sclk, cs_n and mosi itself.
interface gsc_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  // Host end
  modport host (output sclk, output cs_n, output mosi, input miso);
  // Device end
  modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe_n);
endinterface

// *** gsc_host.sv ***
// Host end: SPI master that sends one command per request, mode 0.
// Assumes the device answers one frame later; sclk made here by divider.
module gsc_host
  import gsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // User side
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_word,
  output logic rsp_par_ok,
  // Link
  gsc_if.host spi
);
  typedef enum logic [1:0] {GSC_IDLE, GSC_SHIFT, GSC_GAP} gsc_state_t;
  gsc_state_t state_ff;
  logic [31:0] tx_ff, rx_ff;
  logic [5:0] bits_ff;
  logic [3:0] div_ff;
  logic [3:0] gap_ff;
  logic sclk_ff, cs_n_ff, mosi_ff;
  logic miso_s1_ff, miso_s2_ff;
  logic rsp_valid_ff, rsp_par_ok_ff, cmd_ready_ff;
  logic [31:0] rsp_word_ff;

  // MISO from the pin goes through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
    end else begin
      miso_s1_ff <= spi.miso;
      miso_s2_ff <= miso_s1_ff;
    end
  end

  // Frame engine: 32 clocks under select, then a gap [R05] [R06] [R14] [R03]
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= GSC_IDLE;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      tx_ff <= CMD_RESET_VAL;
      rx_ff <= CMD_RESET_VAL;
      bits_ff <= 6'h00;
      div_ff <= 4'h0;
      gap_ff <= 4'h0;
      rsp_valid_ff <= 1'b0;
      rsp_word_ff <= CMD_RESET_VAL;
      rsp_par_ok_ff <= 1'b0;
      cmd_ready_ff <= 1'b1;
    end else begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        GSC_IDLE: begin
          if (cmd_valid) begin
            // Fill odd parity over the whole command [R20] [R07] [R08]
            tx_ff <= {cmd_word[31:1], odd_fill({cmd_word[31:1], 1'b0})};
            mosi_ff <= cmd_word[31];
            cs_n_ff <= 1'b0;
            bits_ff <= 6'h00;
            div_ff <= HDIV;
            state_ff <= GSC_SHIFT;
            cmd_ready_ff <= 1'b0;
          end
        end
        GSC_SHIFT: begin
          if (div_ff != 4'h0) begin
            div_ff <= div_ff - 4'h1;
          end else begin
            div_ff <= HDIV;
            if (!sclk_ff) begin
              // Rising edge: sample the device [R03]
              sclk_ff <= 1'b1;
              rx_ff <= {rx_ff[30:0], miso_s2_ff};
              bits_ff <= bits_ff + 6'h01;
            end else begin
              sclk_ff <= 1'b0;
              tx_ff <= {tx_ff[30:0], 1'b0};
              mosi_ff <= tx_ff[30];
              if (bits_ff == 6'(FRAME_BITS)) begin
                cs_n_ff <= 1'b1;
                gap_ff <= 4'(GAP_CYC);
                rsp_valid_ff <= 1'b1;
                rsp_word_ff <= rx_ff;
                rsp_par_ok_ff <= ^rx_ff;              // [R19]
                state_ff <= GSC_GAP;
              end
            end
          end
        end
        GSC_GAP: begin
          if (gap_ff != 4'h0) gap_ff <= gap_ff - 4'h1;
          else begin
            state_ff <= GSC_IDLE;                     // [R14]
            cmd_ready_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= GSC_IDLE;
          cmd_ready_ff <= 1'b1;
        end
      endcase
    end
  end

  assign spi.sclk = sclk_ff;
  assign spi.cs_n = cs_n_ff;
  assign spi.mosi = mosi_ff;
  assign cmd_ready = cmd_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_word = rsp_word_ff;
  assign rsp_par_ok = rsp_par_ok_ff;
endmodule

// *** gsc_chk.sv ***
// Checker for the four link wires between host and device ends.
// Assumes sclk is made from mclk by the host, so mclk samples it cleanly.
module gsc_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sq_ff;
  logic [5:0] cnt_ff;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Helper: rising sclk edges counted inside a frame
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sq_ff <= 1'b0;
      cnt_ff <= 6'h00;
    end else begin
      sq_ff <= sclk;
      if (cs_n) begin
        cnt_ff <= 6'h00;
      end else if (sclk && !sq_ff) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  a_oe_tracks_cs: assert property (miso_oe_n == cs_n) else $error("miso enable differs from select");
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("sclk high outside frame");
  a_gap_after_frame: assert property ($rose(cs_n) |=> cs_n) else $error("select gap too short");
  a_frame_clock_count: assert property ($rose(cs_n) |-> cnt_ff == 6'h20) else $error("frame clock count wrong");
  a_bit_limit: assert property (cnt_ff <= 6'h20) else $error("too many clocks in frame");
  a_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved while sclk high");
  a_miso_hold_high: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso)) else $error("miso moved");
  a_lead_low: assert property ($fell(cs_n) |-> !sclk ##1 !sclk) else $error("sclk too soon after select");
  a_high_time: assert property ($rose(sclk) |=> sclk ##1 sclk ##1 !sclk) else $error("sclk high time not three cycles");
endmodule

// *** gyro_spi_command_response_test.sv ***
// Bench: host end drives device end; a second device end is bit-banged.
// Assumes the host fills command parity and answers arrive one frame late.
module gyro_spi_command_response_test
  import gsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] cmd; logic [15:0] rate; logic rv; logic st; logic [5:0] flt; logic [31:0] exp;} gsc_row_t;
  logic mclk, nrst, cmd_valid, cmd_ready, rsp_valid, rsp_par_ok, rate_valid, selftest_mode, frames_done, fd;
  logic [31:0] cmd_word, rsp_word, mo, mi, r, prev, s_cmd;
  logic [15:0] rate_word, snap_rate;
  logic [5:0] fault_flags;
  int err_count, checked;
  gsc_row_t rows [9];
  gsc_if if1();
  gsc_if if2();
  gsc_host gsc_host_inst (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_par_ok(rsp_par_ok), .spi(if1));
  gsc_dev gsc_dev_inst (.spi(if1), .mclk(mclk), .nrst(nrst), .rate_word(rate_word), .rate_valid(rate_valid),
    .selftest_mode(selftest_mode), .fault_flags(fault_flags), .snap_rate(snap_rate), .frames_done(frames_done));
  gsc_dev gsc_dev_inst_b (.spi(if2), .mclk(mclk), .nrst(nrst), .rate_word(rate_word), .rate_valid(rate_valid),
    .selftest_mode(selftest_mode), .fault_flags(fault_flags), .snap_rate(), .frames_done());
  gsc_chk gsc_chk_inst (.mclk(mclk), .nrst(nrst), .sclk(if1.sclk), .cs_n(if1.cs_n), .mosi(if1.mosi),
    .miso(if1.miso), .miso_oe_n(if1.miso_oe_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fill both odd-parity bits of a response
  function automatic logic [31:0] fix(input logic [31:0] v);
    v[28] = ~^v[31:16];
    v[0] = ~^v[31:1];
    return v;
  endfunction
  function automatic logic [31:0] err(input logic [4:0] b, input logic [5:0] f);
    return fix({3'h0, 1'b0, 4'hE, 3'h0, b, 8'h00, f, 2'h0});
  endfunction
  task automatic print_verdict();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, got);
    end
  endtask
  task automatic hang();
    err_count++;
    print_verdict();
  endtask
  // One host transfer: wait ready, present for one edge, wait the answer
  task automatic send(input logic [31:0] c);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 500) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 500) hang();
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_word <= c;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 500);
    if (k == 500) hang();
    r = rsp_word;
    chk("cmd_wire", mo, {c[31:1], ~^c[31:1]});
    chk("par_ok", {31'h0, rsp_par_ok}, 32'h1);
  endtask
  // Bench-made link clock of 48 ns on the second link, still between frames
  task automatic bang(input logic [31:0] c, input int n);
    if2.mosi = c[31];
    if2.cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      #24 if2.sclk = 1'b1;
      r = {r[30:0], if2.miso};
      #24 if2.sclk = 1'b0;
      c = c << 1;
      if2.mosi = c[31];
    end
    #24 if2.cs_n = 1'b1;
    if2.mosi = ~if2.mosi;
    #407;
  endtask
  // Wire monitor on the first link, sampled as the device samples
  always @(posedge if1.sclk) begin
    mo <= {mo[30:0], if1.mosi};
    mi <= {mi[30:0], if1.miso};
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, cmd_valid, cmd_word, rate_word, rate_valid, selftest_mode, fault_flags} = '0;
    {if2.sclk, if2.cs_n, if2.mosi} = 3'b010;
    err_count = 0;
    checked = 0;
    rows[0] = '{{3'h2, 3'h5, 9'h001, 16'hA5C3, 1'b0}, 16'h1111, 1, 0, 6'h00,
      fix({3'h1, 1'b0, 4'hE, 3'h0, 16'hA5C3, 5'h00})};
    rows[1] = '{{3'h4, 3'h7, 9'h001, 17'h0}, 16'h2222, 1, 0, 6'h00,
      fix({3'h2, 1'b0, 4'hE, 3'h0, 16'hA5C3, 5'h00})};
    rows[2] = '{{2'h1, 1'b1, 1'b1, 28'h0}, 16'h1234, 1, 0, 6'h2D,
      fix({3'h5, 1'b0, 2'h1, 16'h1234, 2'h0, 6'h2D, 2'h0})};
    rows[3] = '{{2'h2, 1'b1, 1'b0, 26'h0, 2'h2}, 16'hFFFF, 0, 0, 6'h00,
      fix({3'h2, 1'b0, 2'h0, 16'hFFFF, 2'h0, 6'h00, 2'h2})};
    rows[4] = '{{2'h3, 1'b1, 1'b1, 28'h0}, 16'h8001, 1, 1, 6'h3F,
      fix({3'h7, 1'b0, 2'h2, 16'h8001, 2'h0, 6'h3F, 2'h0})};
    rows[5] = '{{3'h4, 3'h0, 9'h010, 17'h0}, 16'h0000, 1, 0, 6'h15, err(5'h02, 6'h15)};
    rows[6] = '{{3'h2, 3'h0, 9'h008, 16'h0001, 1'b0}, 16'h0000, 1, 0, 6'h0A, err(5'h02, 6'h0A)};
    rows[7] = '{{3'h0, 29'h0}, 16'h0000, 1, 0, 6'h30, err(5'h02, 6'h30)};
    rows[8] = '{{3'h6, 29'h0}, 16'h0000, 1, 0, 6'h01, err(5'h02, 6'h01)};
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    prev = FIRST_RESPONSE;
    fd = 1'b0;
    foreach (rows[i]) begin
      @(posedge mclk);
      {rate_word, rate_valid, selftest_mode, fault_flags} <= {rows[i].rate, rows[i].rv, rows[i].st, rows[i].flt};
      send(rows[i].cmd);
      // Select rise reaches the mclk side through the sync a few cycles later
      repeat (4) @(posedge mclk);
      fd = ~fd;
      chk("frames_done", {31'h0, frames_done}, {31'h0, fd});
      chk("rsp", r, prev);
      chk("rsp_wire", mi, prev);
      chk("snap", {16'h0, snap_rate}, {16'h0, rows[i].rate});
      prev = rows[i].exp;
    end
    send(rows[0].cmd);
    chk("rsp_last", r, prev);
    // Reset in mid-run brings the fixed first answer back
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk("cs_idle", {31'h0, if1.cs_n}, 32'h1);
    send(rows[2].cmd);
    chk("rsp_reset", r, FIRST_RESPONSE);
    // Faulty frames on the second link: short count, then bad parity
    @(posedge mclk);
    {rate_word, rate_valid, selftest_mode, fault_flags} <= {16'h1234, 1'b1, 1'b0, 6'h21};
    s_cmd = {2'h3, 1'b1, 1'b0, 27'h0, 1'b0};
    s_cmd[0] = ~^s_cmd[31:1];
    bang(s_cmd, 32);
    chk("b_first", r, FIRST_RESPONSE);
    bang(s_cmd, 31);
    bang(s_cmd, 32);
    chk("b_count", r, err(5'h04, 6'h21));
    bang(s_cmd ^ 32'h1, 32);
    bang(s_cmd, 32);
    chk("b_parity", r, err(5'h04, 6'h21));
    bang(s_cmd, 32);
    chk("b_recover", r, fix({3'h3, 1'b0, 2'h1, 16'h1234, 2'h0, 6'h21, 2'h0}));
    print_verdict();
  end
endmodule
